// ===== src/asc_map.vh
`ifndef ASC_MAP_VH
`define ASC_MAP_VH
// Register indices (printed values not all multiples of four: byte offset is index * 4)
`define ASC_IDX_SEQ_CTRL    8'h63
`define ASC_IDX_CLK_CTRL    8'h64
`define ASC_IDX_PWR_IRQ     8'h62
`define ASC_IDX_CHAN_CTRL   8'h65
`define ASC_IDX_STATUS      8'h66
`define ASC_IDX_TEST        8'h67
`define ASC_IDX_RESULT0     8'h70
// Control register 3 fields
`define ASC_SEQ_S1_BIT      3
`define ASC_SEQ_FIFO_BIT    2
`define ASC_SEQ_FRZ_HI      1
`define ASC_SEQ_FRZ_LO      0
`define ASC_SEQ_RESET       8'h00
// Control register 4 fields
`define ASC_CLK_RES_BIT     7
`define ASC_CLK_SMP_HI      6
`define ASC_CLK_SMP_LO      5
`define ASC_CLK_PRS_HI      4
`define ASC_CLK_PRS_LO      0
`define ASC_CLK_RESET       8'h01
// Control register 2 fields
`define ASC_PWR_FFC_BIT     6
`define ASC_PWR_IE_BIT      1
`define ASC_PWR_IF_BIT      0
`define ASC_PWR_RESET       8'h00
// Channel control register fields
`define ASC_CHN_S8_BIT      6
`define ASC_CHN_RESET       8'h00
// Test register fields
`define ASC_TST_RST_BIT     0
// Conversion timing in converter clock periods
`define ASC_CONV_CLKS_8B    8'h0A
`define ASC_CONV_CLKS_10B   8'h0C
`define ASC_BUF_SAMPLE_CLKS 8'h04
`endif

// ===== src/asc_clk_div.v
`timescale 1ns/1ps
// Modulus prescaler followed by divide-by-two; emits one-cycle converter clock ticks
module asc_clk_div (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Control
  input  wire       restart,
  input  wire [4:0] divider,
  // Converter clock enable
  output reg        tick
);
  reg [4:0] cnt_q;
  reg       half_q;

  // Counting 0..divider gives a modulus of divider+1; halving doubles it
  always @(posedge aclk) begin
    if (!aresetn || restart) begin
      cnt_q  <= 5'h00;
      half_q <= 1'b0;
      tick   <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (cnt_q >= divider) begin
        cnt_q  <= 5'h00;
        half_q <= ~half_q;
        tick   <= half_q;
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end
endmodule

// ===== src/asc_axil_if.v
`timescale 1ns/1ps
// AXI4-Lite slave front end: takes AW/W in either order, one read at a time
module asc_axil_if (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Register side
  output reg         wr_en,
  output reg  [7:0]  wr_idx,
  output reg  [7:0]  wr_data,
  input  wire        wr_ok,
  output reg         rd_en,
  output reg  [7:0]  rd_idx,
  input  wire [7:0]  rd_data,
  input  wire        rd_ok
);
  reg       aw_have_q;
  reg       w_have_q;
  reg [7:0] w_dat_q;
  reg       w_lane_q;
  reg       rd_wait_q;

  // Write path: capture both halves, then issue one strobe and respond
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      w_dat_q       <= 8'h00;
      w_lane_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
      wr_en         <= 1'b0;
      wr_idx        <= 8'h00;
      wr_data       <= 8'h00;
    end else begin
      wr_en         <= 1'b0;
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        // Index is loaded early so the register side decodes it before the response
        aw_have_q <= 1'b1;
        wr_idx    <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_dat_q  <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        // Byte lane 0 alone carries register data; without it nothing is stored
        wr_en        <= w_lane_q;
        wr_data      <= w_dat_q;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read path: address taken, then one cycle later data together with the side-effect strobe
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'h0;
      rd_en         <= 1'b0;
      rd_idx        <= 8'h00;
      rd_wait_q     <= 1'b0;
    end else begin
      rd_en         <= 1'b0;
      s_axi_arready <= !s_axi_arready && !rd_wait_q && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        rd_idx    <= s_axi_araddr[9:2];
        rd_wait_q <= 1'b1;
      end else if (rd_wait_q) begin
        rd_en        <= 1'b1;
        rd_wait_q    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rd_data};
        s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ===== src/asc_ctrl.v
`timescale 1ns/1ps
`include "asc_map.vh"
// Functional notes
// - Sequence-complete flag with enable set drives the interrupt request.
// - Flag sets only after the last result of the sequence is stored.
// - Flag holds until matching flag clear by read or fast-clear write, restart, or reset.
// - Software writes change the sequence-complete flag only by clearing it, via restart or a fast-clear result write.
// - Sequence/FIFO/freeze register always accessible, upper nibble zero, resets zero.
// - Single-length bit gives one conversion; eight-length bit wins.
// - Non-FIFO results land in register matching sequence position.
// - FIFO mode keeps the result counter across sequences.
// - Result counter wraps to register zero after the last.
// - Status register shows the result counter.
// - Counter clears on reset, non-FIFO start/end, and test reset bit.
// - Setting FIFO mid-sequence continues with the counter where it stands.
// - Freeze bits: continue, reserved, finish-then-freeze, freeze in debug.
// - Leaving debug resumes exactly where the converter stopped.
// - Clock register write aborts and restarts a sequence immediately.
// - Resolution bit picks 8-bit or the longer 10-bit conversion.
// - Final sample phase lasts 2, 4, 8 or 16 converter clocks.
// - Final sample phase follows the buffered sample phase.
// - Prescaler plus one divides bus clock, then halved again.
// - Prescaler resets to one, quarter of the bus clock.
// - Fast clear: any result access clears its flag; else test-index flags read first.
module asc_ctrl (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite
  input  wire [9:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [9:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  // Debug and converter
  input  wire        debug_mode_active,
  input  wire [9:0]  conv_result,
  output reg         sample_direct,
  output reg         conv_active,
  output reg         adc_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Sequencer states
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_BUF  = 5'b00010;
  localparam [4:0] ST_FIN  = 5'b00100;
  localparam [4:0] ST_CONV = 5'b01000;
  localparam [4:0] ST_FRZ  = 5'b10000;

  wire       wr_en;
  wire [7:0] wr_idx;
  wire [7:0] wr_data;
  wire       rd_en;
  wire [7:0] rd_idx;
  reg  [7:0] rd_data;
  reg        rd_ok;
  wire       wr_ok;
  wire       tick;

  reg  [7:0] seq_ctrl_q;
  reg  [7:0] clk_ctrl_q;
  reg  [7:0] chn_ctrl_q;
  reg        fast_flag_clear_q;
  reg        seq_done_irq_enable_q;
  reg        seq_done_irq_flag_q;
  reg        test_rst_q;
  reg  [7:0] conv_done_flag_q;
  reg  [7:0] status_seen_q;
  reg  [9:0] result_q [0:7];
  reg  [2:0] res_ptr_q;
  reg  [3:0] conv_cnt_q;
  reg  [7:0] phase_cnt_q;
  reg  [4:0] state_q;
  reg  [4:0] resume_q;
  reg        frz_pend_q;
  wire       restart;
  wire       fifo_mode;
  wire [1:0] frz_sel;
  wire [3:0] seq_len;
  wire       res_rd;
  wire [2:0] res_sel;
  wire       res_wr;
  wire [7:0] last_clr;

  ////////////////////////////////////////////////////////////////////////////
  // Sequence length from the two length bits
  function [3:0] len_of;
    input s8;
    input s1;
    begin
      if (s8)
        len_of = 4'h8;
      else if (s1)
        len_of = 4'h1;
      else
        len_of = 4'h4;
    end
  endfunction

  // Result register index decode, shared by read and write strobes
  function is_result;
    input [7:0] idx;
    begin
      is_result = (idx[7:3] == `ASC_IDX_RESULT0 >> 3);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  asc_axil_if u_bus (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_en         (wr_en),
    .wr_idx        (wr_idx),
    .wr_data       (wr_data),
    .wr_ok         (wr_ok),
    .rd_en         (rd_en),
    .rd_idx        (rd_idx),
    .rd_data       (rd_data),
    .rd_ok         (rd_ok)
  );

  asc_clk_div u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .restart (restart),
    .divider (clk_ctrl_q[`ASC_CLK_PRS_HI:`ASC_CLK_PRS_LO]),
    .tick    (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decodes shared by several processes
  assign restart   = wr_en && (wr_idx == `ASC_IDX_CLK_CTRL || wr_idx == `ASC_IDX_CHAN_CTRL);
  assign fifo_mode = seq_ctrl_q[`ASC_SEQ_FIFO_BIT];
  assign frz_sel   = seq_ctrl_q[`ASC_SEQ_FRZ_HI:`ASC_SEQ_FRZ_LO];
  assign seq_len   = len_of(chn_ctrl_q[`ASC_CHN_S8_BIT], seq_ctrl_q[`ASC_SEQ_S1_BIT]);
  assign res_rd    = rd_en && is_result(rd_idx);
  assign res_sel   = rd_idx[2:0];
  assign res_wr    = wr_en && is_result(wr_idx);
  assign wr_ok     = (wr_idx == `ASC_IDX_SEQ_CTRL) || (wr_idx == `ASC_IDX_CLK_CTRL) ||
                     (wr_idx == `ASC_IDX_PWR_IRQ) || (wr_idx == `ASC_IDX_CHAN_CTRL) ||
                     (wr_idx == `ASC_IDX_STATUS) || (wr_idx == `ASC_IDX_TEST) || is_result(wr_idx);

  // Read mux; status shows the sequence flag and the next result slot
  always @* begin
    rd_ok   = 1'b1;
    rd_data = 8'h00;
    case (rd_idx)
      `ASC_IDX_SEQ_CTRL:  rd_data = {4'h0, seq_ctrl_q[3:0]};
      `ASC_IDX_CLK_CTRL:  rd_data = clk_ctrl_q;
      `ASC_IDX_CHAN_CTRL: rd_data = chn_ctrl_q;
      `ASC_IDX_PWR_IRQ:   rd_data = {1'b0, fast_flag_clear_q, 4'h0, seq_done_irq_enable_q, seq_done_irq_flag_q};
      `ASC_IDX_STATUS:    rd_data = {seq_done_irq_flag_q, 4'h0, res_ptr_q};
      // Test index reads back the conversion-done flags; the reset bit is write-only
      `ASC_IDX_TEST:      rd_data = conv_done_flag_q;
      default: begin
        if (is_result(rd_idx))
          rd_data = result_q[res_sel][9:2];
        else
          rd_ok = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; the sequence flag has no write path in this process
  always @(posedge aclk) begin
    if (!aresetn) begin
      seq_ctrl_q            <= `ASC_SEQ_RESET;
      clk_ctrl_q            <= `ASC_CLK_RESET;
      chn_ctrl_q            <= `ASC_CHN_RESET;
      fast_flag_clear_q     <= 1'b0;
      seq_done_irq_enable_q <= 1'b0;
      test_rst_q            <= 1'b0;
    end else if (wr_en) begin
      case (wr_idx)
        `ASC_IDX_SEQ_CTRL: seq_ctrl_q <= {4'h0, wr_data[3:0]};
        `ASC_IDX_CLK_CTRL: clk_ctrl_q <= wr_data;
        `ASC_IDX_CHAN_CTRL: chn_ctrl_q <= wr_data;
        `ASC_IDX_PWR_IRQ: begin
          fast_flag_clear_q     <= wr_data[`ASC_PWR_FFC_BIT];
          seq_done_irq_enable_q <= wr_data[`ASC_PWR_IE_BIT];
        end
        `ASC_IDX_TEST: test_rst_q <= wr_data[`ASC_TST_RST_BIT];
        default: test_rst_q <= test_rst_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-result flag clearing: fast mode on any access, else test-index flags read first
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_clr
      assign last_clr[gi] = ((res_rd && res_sel == gi) || (res_wr && wr_idx[2:0] == gi)) &&
                            (fast_flag_clear_q || (status_seen_q[gi] && res_rd));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: buffered sample, final sample, conversion, store
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q             <= ST_IDLE;
      resume_q            <= ST_IDLE;
      frz_pend_q          <= 1'b0;
      res_ptr_q           <= 3'h0;
      conv_cnt_q          <= 4'h0;
      phase_cnt_q         <= 8'h00;
      seq_done_irq_flag_q <= 1'b0;
      conv_done_flag_q    <= 8'h00;
      status_seen_q       <= 8'h00;
      sample_direct       <= 1'b0;
      conv_active         <= 1'b0;
      adc_irq             <= 1'b0;
    end else begin
      adc_irq <= seq_done_irq_flag_q && seq_done_irq_enable_q;
      if (rd_en && rd_idx == `ASC_IDX_STATUS + 8'h01)
        status_seen_q <= conv_done_flag_q;
      if (|last_clr) begin
        conv_done_flag_q    <= conv_done_flag_q & ~last_clr;
        status_seen_q       <= status_seen_q & ~last_clr;
        seq_done_irq_flag_q <= 1'b0;
      end
      if (wr_en && wr_idx == `ASC_IDX_TEST && wr_data[`ASC_TST_RST_BIT] != test_rst_q)
        res_ptr_q <= 3'h0;
      if (restart) begin
        // Abort whatever runs and begin afresh; flags clear on restart
        state_q             <= ST_BUF;
        phase_cnt_q         <= `ASC_BUF_SAMPLE_CLKS;
        conv_cnt_q          <= 4'h0;
        frz_pend_q          <= 1'b0;
        seq_done_irq_flag_q <= 1'b0;
        conv_done_flag_q    <= 8'h00;
        status_seen_q       <= 8'h00;
        sample_direct       <= 1'b0;
        conv_active         <= 1'b1;
        if (!fifo_mode)
          res_ptr_q <= 3'h0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            conv_active <= 1'b0;
          end
          ST_FRZ: begin
            // Hold every counter; return to the saved phase when debug ends
            if (!debug_mode_active || frz_sel == 2'b00 || frz_sel == 2'b01)
              state_q <= resume_q;
          end
          default: begin
            if (debug_mode_active && frz_sel == 2'b11) begin
              resume_q <= state_q;
              state_q  <= ST_FRZ;
            end else if (tick) begin
              if (phase_cnt_q > 8'h01) begin
                phase_cnt_q <= phase_cnt_q - 8'h01;
              end else if (state_q == ST_BUF) begin
                state_q       <= ST_FIN;
                sample_direct <= 1'b1;
                phase_cnt_q   <= 8'h02 << clk_ctrl_q[`ASC_CLK_SMP_HI:`ASC_CLK_SMP_LO];
              end else if (state_q == ST_FIN) begin
                state_q       <= ST_CONV;
                sample_direct <= 1'b0;
                phase_cnt_q   <= clk_ctrl_q[`ASC_CLK_RES_BIT] ? `ASC_CONV_CLKS_10B : `ASC_CONV_CLKS_8B;
              end else begin
                // Store the result; the flag set below sees it already stored
                result_q[res_ptr_q] <= clk_ctrl_q[`ASC_CLK_RES_BIT] ? conv_result : {conv_result[9:2], 2'b00};
                conv_done_flag_q[res_ptr_q] <= 1'b1;
                res_ptr_q   <= res_ptr_q + 3'h1;
                phase_cnt_q <= `ASC_BUF_SAMPLE_CLKS;
                if (conv_cnt_q + 4'h1 >= seq_len) begin
                  conv_cnt_q          <= 4'h0;
                  seq_done_irq_flag_q <= 1'b1;
                  if (!fifo_mode)
                    res_ptr_q <= 3'h0;
                  state_q <= chn_ctrl_q[5] ? ST_BUF : ST_IDLE;
                end else begin
                  conv_cnt_q <= conv_cnt_q + 4'h1;
                  state_q    <= ST_BUF;
                end
                // Finish-then-freeze parks after this conversion
                if (debug_mode_active && frz_sel == 2'b10) begin
                  resume_q <= (conv_cnt_q + 4'h1 >= seq_len && !chn_ctrl_q[5]) ? ST_IDLE : ST_BUF;
                  state_q  <= ST_FRZ;
                end
              end
            end
          end
        endcase
      end
    end
  end
endmodule

// ===== testbench/asc_ctrl_props.sv
`timescale 1ns/1ps
module asc_ctrl_props (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Bus signals watched
  input wire [9:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [9:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  // Converter side
  input wire        debug_mode_active,
  input wire        sample_direct,
  input wire        conv_active,
  input wire        adc_irq
);
  reg  [9:0] aw_q;
  reg  [9:0] ar_q;
  reg        ie_q;
  reg  [1:0] frz_q;
  wire [9:0] wr_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_q;
  wire       wr_hs   = s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  wire       restart = wr_hs && wr_addr == 10'h190;

  ////////////////////////////////////////////////////////////////
  // Shadow of the enable and freeze bits, taken at the data handshake so it leads the register
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_q  <= 10'h000;
      ar_q  <= 10'h000;
      ie_q  <= 1'h0;
      frz_q <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
      if (wr_hs && wr_addr == 10'h188) ie_q <= s_axi_wdata[1];
      if (wr_hs && wr_addr == 10'h18C) frz_q <= s_axi_wdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Six cycles of margin cover the lag of the real enable behind the shadow
  chk_irq_disabled: assert property ((!ie_q) [*6] |-> !adc_irq)
    else $error("interrupt raised while disabled");
  chk_irq_rst_clear: assert property ($rose(aresetn) |-> !adc_irq && !conv_active)
    else $error("activity right after reset");
  chk_restart_clear: assert property (restart |-> ##[1:6] !adc_irq)
    else $error("restart left interrupt pending");
  chk_restart_run: assert property (restart |-> ##[1:6] conv_active)
    else $error("clock register write did not start a sequence");
  chk_seq_upper_zero: assert property (s_axi_rvalid && ar_q == 10'h18C |-> s_axi_rdata[7:4] == 4'h0)
    else $error("sequence register upper bits not zero");
  chk_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above the byte not zero");
  chk_sample_in_seq: assert property (sample_direct |-> conv_active)
    else $error("direct sampling outside a sequence");
  chk_sample_late: assert property ($rose(conv_active) |-> !sample_direct [*4])
    else $error("final sample before buffered phase");
  chk_freeze_hold: assert property ((frz_q == 2'h3 && debug_mode_active) [*3] |->
    $stable(sample_direct) && !$rose(adc_irq))
    else $error("converter moved while frozen");
endmodule

bind asc_ctrl asc_ctrl_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .debug_mode_active, .sample_direct, .conv_active, .adc_irq);

// ===== testbench/tb.sv
`timescale 1ns/1ps
module tb;
  reg         aclk = 1'h0;
  reg         aresetn = 1'h0;
  reg  [9:0]  s_axi_awaddr = 10'h000;
  reg         s_axi_awvalid = 1'h0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_wvalid = 1'h0;
  reg         s_axi_bready = 1'h0;
  reg  [9:0]  s_axi_araddr = 10'h000;
  reg         s_axi_arvalid = 1'h0;
  reg         s_axi_rready = 1'h0;
  reg         debug_mode_active = 1'h0;
  reg  [9:0]  conv_result = 10'h000;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        sample_direct, conv_active, adc_irq;
  integer     failures = 0;
  integer     n_checks = 0;
  integer     cyc = 0;
  integer     base, t, k;
  reg  [7:0]  d;
  reg  [1:0]  resp;

  // 250 MHz clock
  always #2 aclk = ~aclk;

  asc_ctrl dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .debug_mode_active, .conv_result, .sample_direct, .conv_active, .adc_irq);

  ////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task give_verdict;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask

  // A stuck handshake ends here instead of hanging the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures = failures + 1;
      give_verdict;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Register index i lives at byte address i*4; each channel is released on its own ready
  task wr(input [7:0] i, input [7:0] v);
    reg a, w;
    begin
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      a = 1'h1;
      w = 1'h1;
      while (a || w) begin
        @(posedge aclk);
        if (s_axi_awready) a = 1'h0;
        if (s_axi_wready) w = 1'h0;
        s_axi_awvalid <= a;
        s_axi_wvalid <= w;
      end
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'h0;
    end
  endtask

  task rd(input [7:0] i);
    begin
      @(posedge aclk);
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'h0;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'h0;
      d = s_axi_rdata[7:0];
      resp = s_axi_rresp;
    end
  endtask

  task rc(input [7:0] i, input [7:0] m, input [7:0] e);
    begin
      rd(i);
      chk(d & m, e);
    end
  endtask

  // Write, then count cycles to the interrupt; debug is held for hold cycles from cycle 20
  task seq(input [7:0] i, input [7:0] v, input integer hold);
    begin
      wr(i, v);
      repeat (2) @(posedge aclk);
      t = 0;
      while (!adc_irq) begin
        @(posedge aclk);
        debug_mode_active <= (t >= 20 && t < 20 + hold);
        t = t + 1;
      end
      debug_mode_active <= 1'h0;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      rc(8'h63, 8'hFF, 8'h00);
      rc(8'h64, 8'hFF, 8'h01);
      rd(8'h3F);
      chk({resp, d}, {2'h2, 8'h00});
      wr(8'h63, 8'hFF);
      rc(8'h63, 8'hFF, 8'h0F);
      $display("reset and register test done");
    end
  endtask

  task t_seq;
    begin
      wr(8'h63, 8'h00);
      wr(8'h62, 8'h02);
      conv_result <= 10'h2A5;
      seq(8'h65, 8'h00, 0);
      wr(8'h62, 8'h02);
      rd(8'h70);
      rc(8'h62, 8'h03, 8'h03);
      rc(8'h66, 8'h87, 8'h80);
      rc(8'h67, 8'hFF, 8'h0F);
      for (k = 0; k < 4; k = k + 1) rc(8'h70 + k[7:0], 8'hFF, 8'hA9);
      rc(8'h62, 8'h01, 8'h00);
      chk(adc_irq, 1'h0);
      $display("four conversion sequence test done");
    end
  endtask

  task t_len;
    begin
      wr(8'h63, 8'h08);
      conv_result <= 10'h155;
      seq(8'h65, 8'h00, 0);
      rc(8'h70, 8'hFF, 8'h55);
      rc(8'h71, 8'hFF, 8'hA9);
      conv_result <= 10'h3FC;
      seq(8'h65, 8'h40, 0);
      rc(8'h77, 8'hFF, 8'hFF);
      wr(8'h62, 8'h42);
      rd(8'h77);
      rc(8'h67, 8'hFF, 8'h7F);
      rc(8'h66, 8'h07, 8'h00);
      $display("sequence length test done");
    end
  endtask

  task t_fifo;
    begin
      wr(8'h63, 8'h0C);
      for (k = 1; k < 10; k = k + 1) begin
        conv_result <= {k[7:0], 2'h0};
        seq(8'h65, 8'h00, 0);
        rc(8'h66, 8'h07, {5'h0, k[2:0]});
      end
      rc(8'h70, 8'hFF, 8'h09);
      rc(8'h77, 8'hFF, 8'h08);
      wr(8'h63, 8'h00);
      wr(8'h65, 8'h00);
      seq(8'h63, 8'h04, 0);
      rc(8'h66, 8'h07, 8'h04);
      wr(8'h67, 8'h01);
      wr(8'h67, 8'h00);
      rc(8'h66, 8'h07, 8'h00);
      $display("fifo mode test done");
    end
  endtask

  // Differences of run times cancel the fixed bus overhead
  task t_time;
    begin
      wr(8'h63, 8'h08);
      seq(8'h64, 8'h01, 0);
      base = t;
      seq(8'h64, 8'h81, 0);
      chk(t - base, 8);
      for (k = 1; k < 4; k = k + 1) begin
        seq(8'h64, {1'h0, k[1:0], 5'h01}, 0);
        chk(t - base, ((2 << k) - 2) * 4);
      end
      seq(8'h64, 8'h00, 0);
      k = base - t;
      seq(8'h64, 8'h02, 0);
      chk(t - base, k);
      for (k = 0; k < 4; k = k + 3) begin
        wr(8'h63, {6'h02, k[1:0]});
        seq(8'h64, 8'h01, 100);
        chk(t - base, (k == 3) ? 100 : 0);
      end
      $display("timing and freeze test done");
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_seq;
    t_len;
    t_fifo;
    t_time;
    give_verdict;
  end
endmodule
